//--- pkg/tcs_pkg.sv
// tcs_pkg: constants and carrier types of the tag configuration/session bank
package tcs_pkg;

	// reader-side page addresses
	localparam logic [7:0] TCS_RD_CFG_A   = 8'hE8;
	localparam logic [7:0] TCS_RD_CFG_B   = 8'hE9;
	localparam logic [7:0] TCS_RD_SES_A   = 8'hEC;
	localparam logic [7:0] TCS_RD_SES_B   = 8'hED;
	localparam logic [7:0] TCS_RD_MIR_A   = 8'hF8;
	localparam logic [7:0] TCS_RD_MIR_B   = 8'hF9;
	localparam logic [1:0] TCS_MIR_SECTOR = 2'h3;
	localparam logic [1:0] TCS_CFG_SECTOR = 2'h0;

	// host-side block addresses (one block covers both pages)
	localparam logic [7:0] TCS_HB_CFG     = 8'h3A;
	localparam logic [7:0] TCS_HB_SES     = 8'hFE;

	// byte slots within a page
	localparam int TCS_BYTE_CTRL   = 0;
	localparam int TCS_BYTE_FINAL  = 1;
	localparam int TCS_BYTE_WINDOW = 2;
	localparam int TCS_BYTE_WDLOW  = 3;
	localparam int TCS_BYTE_WDHIGH = 0;
	localparam int TCS_BYTE_STRETCH = 1;
	localparam int TCS_BYTE_LOCK   = 2;
	localparam int TCS_BYTE_RSVD   = 3;

	// control byte fields
	localparam int TCS_BIT_SILENCE = 7;
	localparam int TCS_BIT_PTHRU   = 6;

	// persistent defaults at first use of the memory
	localparam logic [31:0] TCS_CFG_A_RST = 32'h0000_0000;
	localparam logic [31:0] TCS_CFG_B_RST = 32'h0000_0000;

	localparam logic [31:0] TCS_UNMAPPED = 32'h0000_0000;

	// one access from either party
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [1:0]  sector;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} tcs_req_s;

	typedef struct packed {
		logic        done;
		logic        ack;
		logic [31:0] rdata;
	} tcs_rsp_s;

	typedef enum logic [0:0] {
		TCS_SRC_READER,
		TCS_SRC_HOST
	} tcs_src_e;

endpackage : tcs_pkg

//--- design/tcs_page_store.sv
// tcs_page_store: one 32-bit page of persistent configuration storage
`timescale 1ns/1ps
`default_nettype none
module tcs_page_store
	import tcs_pkg::*;
#(
	parameter logic [31:0] INIT = 32'h0000_0000
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// write side
	input  wire logic        wr_en,
	input  wire logic [31:0] wr_data,
	// contents
	output var  logic [31:0] q
);

	// non-volatile contents: present from time zero, never touched by reset
	logic [31:0] q_reg = INIT;
	logic [31:0] q_next;

	// writes during power-on reset are dropped, no programming cycle starts
	always_comb begin
		q_next = q_reg;
		if (wr_en && !reset) begin
			q_next = wr_data;
		end
	end

	always_ff @(posedge mclk) begin
		q_reg <= q_next;
	end

	assign q = q_reg;

endmodule : tcs_page_store
`default_nettype wire

//--- design/tcs_bank.sv
// tcs_bank: configuration and session register bank with reader and host ports
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - persistent copy at two reader pages, host block
// - both ports access persistent, locked refuses writes
// - session copy: reader read-only, host read-write
// - session mirrored at sector-3 pages F8h-F9h
// - power-on reset loads session from persistent
// - session writes act at once, until reset
// - persistent writes act only after reset; a lock byte write acts at once
// - lock byte persistent only, status byte session
// - two pages, fixed byte layout
// - control bit 7 enables silence and soft reset
// - control bit 6 enables pass-through mapping
// - host always may access session copy
module tcs_bank
	import tcs_pkg::*;
(
	// clock and power-on reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// reader side
	input  wire tcs_req_s    rd_req,
	output var  tcs_rsp_s    rd_rsp,
	// host side: block accesses and register operations
	input  wire tcs_req_s    host_req,
	input  wire logic        host_reg_op,
	input  wire logic [1:0]  host_page,
	output var  tcs_rsp_s    host_rsp,
	// live status byte from the rest of the device
	input  wire logic [7:0]  status_in,
	// effective session controls and the persistent lock flag
	output var  logic        silence_and_soft_reset_enable,
	output var  logic        passthrough_enable,
	output var  logic [7:0]  final_message_block,
	output var  logic [7:0]  buffer_window_block,
	output var  logic [15:0] watchdog_time,
	output var  logic [7:0]  host_clock_stretch_enable,
	output var  logic        config_locked
);

	logic [31:0] cfg_a;
	logic [31:0] cfg_b;
	logic        cfg_a_wr;
	logic        cfg_b_wr;
	logic [31:0] cfg_a_wdata;
	logic [31:0] cfg_b_wdata;

	logic [31:0] ses_a_reg;
	logic [31:0] ses_a_next;
	logic [31:0] ses_b_reg;
	logic [31:0] ses_b_next;
	tcs_rsp_s    rd_rsp_reg;
	tcs_rsp_s    rd_rsp_next;
	tcs_rsp_s    host_rsp_reg;
	tcs_rsp_s    host_rsp_next;
	logic        locked;

	// the persistent pages sit outside the reset so they survive power-on
	tcs_page_store #(.INIT(TCS_CFG_A_RST)) u_cfg_a (
		.mclk    (mclk),
		.reset   (reset),
		.wr_en   (cfg_a_wr),
		.wr_data (cfg_a_wdata),
		.q       (cfg_a)
	);

	tcs_page_store #(.INIT(TCS_CFG_B_RST)) u_cfg_b (
		.mclk    (mclk),
		.reset   (reset),
		.wr_en   (cfg_b_wr),
		.wr_data (cfg_b_wdata),
		.q       (cfg_b)
	);

	assign locked = cfg_b[TCS_BYTE_LOCK*8 +: 8] != 8'h00;

	// session view with the status byte in the lock slot
	function automatic logic [31:0] ses_b_view(input logic [31:0] b,
	                                           input logic [7:0] st);
		logic [31:0] v;
		v = b;
		v[TCS_BYTE_LOCK*8 +: 8] = st;
		return v;
	endfunction : ses_b_view

	always_comb begin
		ses_a_next    = ses_a_reg;
		ses_b_next    = ses_b_reg;
		cfg_a_wr      = 1'b0;
		cfg_b_wr      = 1'b0;
		cfg_a_wdata   = TCS_UNMAPPED;
		cfg_b_wdata   = TCS_UNMAPPED;
		rd_rsp_next   = '0;
		host_rsp_next = '0;

		// reader port
		if (rd_req.valid) begin
			rd_rsp_next.done = 1'b1;
			rd_rsp_next.ack  = 1'b1;
			if (rd_req.sector == TCS_CFG_SECTOR
			    && rd_req.addr == TCS_RD_CFG_A) begin
				rd_rsp_next.rdata = cfg_a;
				if (rd_req.write) begin
					if (locked) begin
						rd_rsp_next.ack = 1'b0;
					end else begin
						cfg_a_wr    = 1'b1;
						cfg_a_wdata = rd_req.wdata;
					end
				end
			end else if (rd_req.sector == TCS_CFG_SECTOR
			             && rd_req.addr == TCS_RD_CFG_B) begin
				rd_rsp_next.rdata = cfg_b;
				if (rd_req.write) begin
					if (locked) begin
						rd_rsp_next.ack = 1'b0;
					end else begin
						cfg_b_wr    = 1'b1;
						cfg_b_wdata = rd_req.wdata;
					end
				end
			end else if ((rd_req.sector == TCS_CFG_SECTOR
			              && rd_req.addr == TCS_RD_SES_A)
			             || (rd_req.sector == TCS_MIR_SECTOR
			              && rd_req.addr == TCS_RD_MIR_A)) begin
				rd_rsp_next.rdata = ses_a_reg;
				rd_rsp_next.ack   = !rd_req.write;
			end else if ((rd_req.sector == TCS_CFG_SECTOR
			              && rd_req.addr == TCS_RD_SES_B)
			             || (rd_req.sector == TCS_MIR_SECTOR
			              && rd_req.addr == TCS_RD_MIR_B)) begin
				rd_rsp_next.rdata = ses_b_view(ses_b_reg, status_in);
				rd_rsp_next.ack   = !rd_req.write;
			end else begin
				rd_rsp_next.ack = 1'b0;
			end
		end

		// host port; host_page picks page 0 or 1 of the block
		if (host_req.valid) begin
			host_rsp_next.done = 1'b1;
			host_rsp_next.ack  = 1'b1;
			if (!host_reg_op && host_req.addr == TCS_HB_CFG) begin
				host_rsp_next.rdata = host_page[0] ? cfg_b : cfg_a;
				if (host_req.write) begin
					if (locked) begin
						host_rsp_next.ack = 1'b0;
					end else if (host_page[0]) begin
						cfg_b_wr    = 1'b1;
						cfg_b_wdata = host_req.wdata;
					end else begin
						cfg_a_wr    = 1'b1;
						cfg_a_wdata = host_req.wdata;
					end
				end
			end else if (host_reg_op && host_req.addr == TCS_HB_SES) begin
				// no protection term: session access is always granted
				host_rsp_next.rdata = host_page[0]
					? ses_b_view(ses_b_reg, status_in) : ses_a_reg;
				if (host_req.write) begin
					if (host_page[0]) begin
						ses_b_next = host_req.wdata;
					end else begin
						ses_a_next = host_req.wdata;
					end
				end
			end else begin
				host_rsp_next.ack = 1'b0;
			end
		end

		// two persistent writes to one page in a cycle: the host, last, wins

		if (reset) begin
			ses_a_next    = cfg_a;
			ses_b_next    = cfg_b;
			rd_rsp_next   = '0;
			host_rsp_next = '0;
		end
	end

	always_ff @(posedge mclk) begin
		ses_a_reg    <= ses_a_next;
		ses_b_reg    <= ses_b_next;
		rd_rsp_reg   <= rd_rsp_next;
		host_rsp_reg <= host_rsp_next;
	end

	assign rd_rsp   = rd_rsp_reg;
	assign host_rsp = host_rsp_reg;

	// behaviour follows the session copy, except config_locked, which follows the persistent lock byte
	assign silence_and_soft_reset_enable =
		ses_a_reg[TCS_BYTE_CTRL*8 + TCS_BIT_SILENCE];
	assign passthrough_enable =
		ses_a_reg[TCS_BYTE_CTRL*8 + TCS_BIT_PTHRU];
	assign final_message_block = ses_a_reg[TCS_BYTE_FINAL*8 +: 8];
	assign buffer_window_block = ses_a_reg[TCS_BYTE_WINDOW*8 +: 8];
	assign watchdog_time = {ses_b_reg[TCS_BYTE_WDHIGH*8 +: 8],
	                        ses_a_reg[TCS_BYTE_WDLOW*8 +: 8]};
	assign host_clock_stretch_enable = ses_b_reg[TCS_BYTE_STRETCH*8 +: 8];
	assign config_locked = locked;

	session_load_a: assert property (@(posedge mclk)
		reset |=> ses_a_reg == $past(cfg_a))
		else $error("session page a not loaded from persistent copy");

	session_load_b_a: assert property (@(posedge mclk)
		reset |=> ses_b_reg == $past(cfg_b))
		else $error("session page b not loaded from persistent copy");

	lock_refuse_a: assert property (@(posedge mclk) disable iff (reset)
		rd_req.valid && rd_req.write && locked
		&& rd_req.sector == TCS_CFG_SECTOR && rd_req.addr == TCS_RD_CFG_A
		|=> cfg_a == $past(cfg_a) && !rd_rsp.ack)
		else $error("locked persistent page was written");

	reader_ro_a: assert property (@(posedge mclk) disable iff (reset)
		rd_req.valid && rd_req.write && !host_req.valid
		|=> ses_a_reg == $past(ses_a_reg)
		&& ses_b_reg == $past(ses_b_reg))
		else $error("reader changed session copy");

	mirror_same_a: assert property (@(posedge mclk) disable iff (reset)
		rd_req.valid && !rd_req.write && rd_req.sector == TCS_MIR_SECTOR
		&& rd_req.addr == TCS_RD_MIR_A
		|=> rd_rsp.ack && rd_rsp.rdata == $past(ses_a_reg))
		else $error("mirror page differs from session page");

	host_ses_wr_a: assert property (@(posedge mclk) disable iff (reset)
		host_req.valid && host_req.write && host_reg_op
		&& host_req.addr == TCS_HB_SES && !host_page[0]
		&& !rd_req.valid
		|=> ses_a_reg == $past(host_req.wdata)
		&& passthrough_enable == $past(host_req.wdata[TCS_BIT_PTHRU])
		&& cfg_a == $past(cfg_a))
		else $error("host session write not applied at once");

	cfg_no_effect_a: assert property (@(posedge mclk) disable iff (reset)
		cfg_a_wr |=> ses_a_reg == $past(ses_a_reg)
		|| $past(host_req.valid && host_reg_op))
		else $error("persistent write changed live behaviour");

	silence_bit_a: assert property (@(posedge mclk)
		reset |=> silence_and_soft_reset_enable
		== $past(cfg_a[TCS_BYTE_CTRL*8 + TCS_BIT_SILENCE])
		&& passthrough_enable
		== $past(cfg_a[TCS_BYTE_CTRL*8 + TCS_BIT_PTHRU]))
		else $error("control bits not taken from persistent control byte");

endmodule : tcs_bank
`default_nettype wire

//--- tb/tcs_partner.sv
// tcs_partner: reader and host requester model facing the bank
`timescale 1ns/1ps
`default_nettype none
module tcs_partner
	import tcs_pkg::*;
(
	// clock
	input  wire logic       mclk,
	// requests
	output var  tcs_req_s   rd_req,
	output var  tcs_req_s   host_req,
	output var  logic       host_reg_op,
	output var  logic [1:0] host_page,
	// answers
	input  wire tcs_rsp_s   rd_rsp,
	input  wire tcs_rsp_s   host_rsp
);
	initial begin
		rd_req = '0;
		host_req = '0;
		host_reg_op = 1'b0;
		host_page = 2'h0;
	end
	// one-cycle request; idle fields show the inverse so stale values never match
	task automatic acc(input logic h, input logic w, input logic [1:0] sec,
		input logic [7:0] ad, input logic [31:0] wd, input logic op,
		input logic [1:0] pg, output logic [1:0] da, output logic [31:0] rd);
		tcs_req_s r;
		tcs_rsp_s s;
		r = '{valid: 1'b1, write: w, sector: sec, addr: ad, wdata: wd};
		@(negedge mclk);
		if (h) begin
			host_req = r;
			host_reg_op = op;
			host_page = pg;
		end else begin
			rd_req = r;
		end
		@(negedge mclk);
		s = h ? host_rsp : rd_rsp;
		da = {s.done, s.ack};
		rd = s.rdata;
		r = ~r;
		r.valid = 1'b0;
		if (h) begin
			host_req = r;
			host_reg_op = ~op;
			host_page = ~pg;
		end else begin
			rd_req = r;
		end
	endtask : acc
endmodule : tcs_partner
`default_nettype wire

//--- tb/tb_top.sv
// tb_top: self-checking bench of the configuration/session bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import tcs_pkg::*;
;
	logic        mclk;
	logic        reset;
	logic [7:0]  status_in;
	tcs_req_s    rd_req;
	tcs_req_s    host_req;
	logic        host_reg_op;
	logic [1:0]  host_page;
	tcs_rsp_s    rd_rsp;
	tcs_rsp_s    host_rsp;
	logic        sil;
	logic        pth;
	logic [7:0]  fmb;
	logic [7:0]  bwb;
	logic [15:0] wdt;
	logic [7:0]  hcs;
	logic        config_locked;
	logic [1:0]  da;
	logic [31:0] rd;
	logic [31:0] a;
	logic [31:0] b;
	logic [31:0] s;
	int          error_cnt;
	int          n_tests;
	int          cyc;
	int          seed;
	wire  [63:0] outs = {22'h0, sil, pth, fmb, bwb, wdt, hcs};

	tcs_bank tcs_bank_i (.mclk(mclk), .reset(reset), .rd_req(rd_req),
		.rd_rsp(rd_rsp), .host_req(host_req), .host_reg_op(host_reg_op),
		.host_page(host_page), .host_rsp(host_rsp), .status_in(status_in),
		.silence_and_soft_reset_enable(sil), .passthrough_enable(pth),
		.final_message_block(fmb), .buffer_window_block(bwb),
		.watchdog_time(wdt), .host_clock_stretch_enable(hcs),
		.config_locked(config_locked));
	tcs_partner tcs_partner_i (.mclk(mclk), .rd_req(rd_req),
		.host_req(host_req), .host_reg_op(host_reg_op),
		.host_page(host_page), .rd_rsp(rd_rsp), .host_rsp(host_rsp));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// session controls expected from session pages a and b
	function automatic logic [63:0] eo(input logic [31:0] pa,
	                                   input logic [31:0] pb);
		return {22'h0, pa[7], pa[6], pa[15:8], pa[23:16], pb[7:0], pa[31:24],
			pb[15:8]};
	endfunction : eo

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	task automatic t(input logic h, input logic w, input logic [1:0] sec,
		input logic [7:0] ad, input logic [31:0] wd, input logic op,
		input logic [1:0] pg);
		tcs_partner_i.acc(h, w, sec, ad, wd, op, pg, da, rd);
	endtask : t

	task automatic por;
		@(negedge mclk);
		reset = 1'b1;
		@(negedge mclk);
		reset = 1'b0;
	endtask : por

	// ceiling well above the roughly 84 cycles the sequence needs
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			stop_test();
		end
	end

	initial begin
		seed = 94802;
		reset = 1'b1;
		status_in = 8'h00;
		error_cnt = 0;
		n_tests = 0;
		cyc = 0;
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		status_in = 8'($random(seed));
		// lock byte kept clear until the lock test
		a = $random(seed);
		b = $random(seed) & 32'hFF00_FFFF;
		t(0, 1, TCS_CFG_SECTOR, TCS_RD_CFG_A, a, 0, 0);
		chk(da, 2'b11);
		t(1, 1, 0, TCS_HB_CFG, b, 0, 1);
		chk(da, 2'b11);
		t(1, 0, 0, TCS_HB_CFG, 0, 0, 0);
		chk(rd, a);
		t(0, 0, TCS_CFG_SECTOR, TCS_RD_CFG_B, 0, 0, 0);
		chk(rd, b);
		chk(config_locked, 1'b0);
		chk(outs, eo(TCS_CFG_A_RST, TCS_CFG_B_RST));
		$display("test persistent done");
		por();
		chk(outs, eo(a, b));
		for (int i = 0; i < 2; i++) begin
			t(0, 0, i ? TCS_MIR_SECTOR : TCS_CFG_SECTOR,
				i ? TCS_RD_MIR_A : TCS_RD_SES_A, 0, 0, 0);
			chk(rd, a);
			t(0, 0, i ? TCS_MIR_SECTOR : TCS_CFG_SECTOR,
				i ? TCS_RD_MIR_B : TCS_RD_SES_B, 0, 0, 0);
			chk(rd, {b[31:24], status_in, b[15:0]});
		end
		$display("test reload done");
		s = $random(seed);
		t(0, 1, 0, TCS_RD_SES_A, s, 0, 0);
		chk(da, 2'b10);
		t(0, 1, TCS_MIR_SECTOR, TCS_RD_MIR_B, s, 0, 0);
		chk(da, 2'b10);
		t(1, 1, 0, TCS_HB_SES, s, 0, 0);
		chk(da, 2'b10);
		t(1, 1, 0, TCS_HB_CFG, s, 1, 0);
		chk(da, 2'b10);
		t(0, 0, 0, 8'h10, 0, 0, 0);
		chk(da, 2'b10);
		chk(outs, eo(a, b));
		t(1, 1, 0, TCS_HB_SES, s, 1, 0);
		chk(da, 2'b11);
		chk(outs, eo(s, b));
		t(0, 0, 0, TCS_RD_SES_A, 0, 0, 0);
		chk(rd, s);
		t(1, 0, 0, TCS_HB_CFG, 0, 0, 0);
		chk(rd, a);
		// session page b from the host: live status shows in the lock slot
		t(1, 1, 0, TCS_HB_SES, s, 1, 1);
		chk(da, 2'b11);
		chk(outs, eo(s, s));
		t(1, 0, 0, TCS_HB_SES, 0, 1, 1);
		chk(rd, {s[31:24], status_in, s[15:0]});
		t(1, 0, 0, TCS_HB_CFG, 0, 0, 1);
		chk(rd, b);
		for (int k = 0; k < 4; k++) begin
			t(1, 1, 0, TCS_HB_SES, {s[31:8], k[1:0], s[5:0]}, 1, 0);
			chk({sil, pth}, k[1:0]);
		end
		$display("test session done");
		// both copies written so the value survives the next reset
		t(1, 1, 0, TCS_HB_SES, s, 1, 0);
		t(0, 1, 0, TCS_RD_CFG_A, s, 0, 0);
		por();
		chk(outs, eo(s, b));
		t(1, 1, 0, TCS_HB_CFG, b | 32'h0001_0000, 0, 1);
		chk(config_locked, 1'b1);
		t(0, 1, 0, TCS_RD_CFG_A, ~s, 0, 0);
		chk(da, 2'b10);
		t(1, 1, 0, TCS_HB_CFG, ~s, 0, 0);
		chk(da, 2'b10);
		t(1, 0, 0, TCS_HB_CFG, 0, 0, 0);
		chk(rd, s);
		t(1, 1, 0, TCS_HB_SES, a, 1, 0);
		chk(da, 2'b11);
		status_in = 8'($random(seed));
		por();
		t(0, 0, 0, TCS_RD_SES_B, 0, 0, 0);
		chk(rd, {b[31:24], status_in, b[15:0]});
		$display("test lock done");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
